// >>> bench/sts_analog_model.sv
/* comparators, temperature sensor and cpu vector handling around the supervisor.
   assumes: the bench sets the wanted comparator levels. */
`timescale 1ns/1ps
`default_nettype none
module sts_analog_model (
   input  wire logic mclk_i, want_low_i, want_brown_i, want_hot_i, auto_ack_i, irq_i,
   output wire logic low_o, brown_o, hot_o,
   output logic      ack_o
);
   // comparators switch between clock edges
   assign #3 low_o = want_low_i;
   assign #3 brown_o = want_brown_i;
   assign #3 hot_o = want_hot_i;
   // cpu runs the vector one cycle after the request
   always @(posedge mclk_i) ack_o <= auto_ack_i && irq_i && !ack_o;
endmodule
`default_nettype wire

// >>> bench/sts_monitor.sv
/* port checker of the supply and temperature supervisor.
   assumes: bound to sts_supervisor by the statement at the foot. */
`timescale 1ns/1ps
`default_nettype none
module sts_monitor (
   // clock, reset and register port
   input wire logic       mclk_i, rst_i, wr_i, rd_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i, rdata_o,
   // cpu and analog side
   input wire logic       global_irq_en_i, powerdown_i, brownout_cmp_i,
   input wire logic       supply_low_irq_o, supply_monitor_on_o, temp_sensor_on_o,
   input wire logic [2:0] supply_monitor_level_o,
   input wire logic       brownout_level_sel_o, brownout_det_on_o,
   input wire logic       internal_reset_o, periph_hold_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   sequence s_mon_wr;
      wr_i && addr_i == 4'h0;
   endsequence
   sequence s_brown_low;
      (brownout_cmp_i && brownout_det_on_o) [*4];
   endsequence
   a_temp_reserved_zero: assert property (rd_i && addr_i == 4'h1 |=> rdata_o[7:1] == 7'h00)
      else $error("temp control reserved bits not zero");
   a_temp_dis_write: assert property (wr_i && addr_i == 4'h1 ##1 !internal_reset_o
      |=> temp_sensor_on_o == !$past(wdata_i[0], 2))
      else $error("sensor enable does not follow disable bit");
   a_sensor_after_reset: assert property ($fell(rst_i) |=> temp_sensor_on_o)
      else $error("shutdown not enabled after reset");
   a_hold_means_reset: assert property (periph_hold_o |-> internal_reset_o)
      else $error("hold without reset request");
   a_mon_on_write: assert property (s_mon_wr |=> ##1
      supply_monitor_on_o == ($past(wdata_i[0], 2) && !periph_hold_o))
      else $error("monitor enable wrong");
   a_level_write: assert property (s_mon_wr |=> ##1 supply_monitor_level_o == $past(wdata_i[3:1], 2))
      else $error("monitor level wrong");
   a_irq_needs_gen: assert property (supply_low_irq_o |-> $past(global_irq_en_i))
      else $error("supply low request without global enable");
   a_bo_level_write: assert property (s_mon_wr |=> ##1 brownout_level_sel_o == $past(wdata_i[7], 2))
      else $error("brownout level select wrong");
   a_bo_det_awake: assert property (!rst_i && !powerdown_i |=> brownout_det_on_o)
      else $error("brownout detector off while awake");
   a_brown_reset: assert property (s_brown_low |-> ##[0:2] internal_reset_o)
      else $error("no internal reset on brownout");
endmodule
bind sts_supervisor sts_monitor u_mon (.mclk_i(mclk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .global_irq_en_i(global_irq_en_i),
   .powerdown_i(powerdown_i), .brownout_cmp_i(brownout_cmp_i), .periph_hold_o(periph_hold_o),
   .supply_low_irq_o(supply_low_irq_o), .supply_monitor_on_o(supply_monitor_on_o),
   .temp_sensor_on_o(temp_sensor_on_o), .supply_monitor_level_o(supply_monitor_level_o),
   .brownout_level_sel_o(brownout_level_sel_o), .brownout_det_on_o(brownout_det_on_o),
   .internal_reset_o(internal_reset_o));
`default_nettype wire

// >>> bench/sts_supervisor_tb.sv
/* self-checking bench of the supply and temperature supervisor.
   assumes: checker and analog model compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin err_count++; \
   $display("unexpected %s expected %h seen %h", n, e, a); end end
module sts_supervisor_tb;
   logic        mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, gen = 1'b0, pd = 1'b0;
   logic        w_low = 1'b0, w_brown = 1'b0, w_hot = 1'b0, auto_ack = 1'b0;
   logic        low, brown, hot, ack, sl_irq, irq, mon_on, bo_sel, bo_on, ts_on, int_rst, hold;
   logic [3:0]  addr_i = 4'h0;
   logic [7:0]  wdata_i = 8'h00, rdata_o;
   logic [2:0]  lvl;
   logic [31:0] seed = 32'h0000_004a;
   int          err_count = 0, tests_run = 0;
   sts_supervisor u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .global_irq_en_i(gen),
      .supply_vec_ack_i(ack), .powerdown_i(pd), .supply_low_irq_o(sl_irq), .irq_o(irq),
      .supply_low_cmp_i(low), .brownout_cmp_i(brown), .overtemp_cmp_i(hot),
      .supply_monitor_level_o(lvl), .supply_monitor_on_o(mon_on), .brownout_level_sel_o(bo_sel),
      .brownout_det_on_o(bo_on), .temp_sensor_on_o(ts_on), .internal_reset_o(int_rst),
      .periph_hold_o(hold));
   sts_analog_model u_analog (.mclk_i(mclk_i), .want_low_i(w_low), .want_brown_i(w_brown),
      .want_hot_i(w_hot), .auto_ack_i(auto_ack), .irq_i(sl_irq), .low_o(low), .brown_o(brown),
      .hot_o(hot), .ack_o(ack));
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      // registered copies of the written bits settle one edge later
      @(posedge mclk_i);
      #1;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
   endtask
   task automatic wait_edges(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      wait_edges(3000);
      err_count++;
      complete_run();
   end
   initial begin
      logic [31:0] r;
      logic [7:0]  v;
      repeat (10) @(posedge mclk_i);
      rst_i <= 1'b0;
      wr(4'h7, 8'hff);
      `CHK("sensor on", 1'b1, ts_on)
      for (int a = 0; a < 8; a++) begin
         rd(a[3:0]);
         `CHK("reset read", 8'h00, rdata_o)
      end
      for (int i = 0; i < 8; i++) begin
         r = xs();
         v = {r[7:6], 1'b0, r[4], i[2:0], r[0]};
         wr(4'h0, v);
         `CHK("level", i[2:0], lvl)
         `CHK("monitor on", v[0], mon_on)
         `CHK("brownout select", v[7], bo_sel)
         rd(4'h0);
         `CHK("monitor reg", v, rdata_o)
      end
      wr(4'h1, 8'hff);
      `CHK("sensor off", 1'b0, ts_on)
      rd(4'h1);
      `CHK("temp reg", 8'h01, rdata_o)
      w_hot <= 1'b1;
      wait_edges(6);
      `CHK("hot ignored", 1'b0, int_rst)
      wr(4'h1, 8'h00);
      wait_edges(6);
      `CHK("hold", 1'b1, hold)
      `CHK("hot reset", 1'b1, int_rst)
      rd(4'h4);
      `CHK("cause hot", 8'h01, rdata_o)
      w_hot <= 1'b0;
      wait_edges(6);
      wr(4'h4, 8'h01);
      `CHK("reset released", 1'b0, int_rst)
      wr(4'h2, 8'hff);
      wr(4'h3, 8'h01);
      wr(4'h0, 8'h11);
      gen <= 1'b1;
      w_low <= 1'b1;
      wait_edges(6);
      w_low <= 1'b0;
      `CHK("supply request", 1'b1, sl_irq)
      `CHK("irq line", 1'b1, irq)
      wr(4'h0, 8'h11);
      rd(4'h0);
      `CHK("flag kept", 8'h31, rdata_o)
      @(posedge mclk_i);
      gen <= 1'b0;
      wait_edges(2);
      `CHK("global gate", 1'b0, sl_irq)
      wr(4'h0, 8'h31);
      rd(4'h0);
      `CHK("flag cleared", 8'h11, rdata_o)
      wr(4'h2, 8'h01);
      `CHK("irq cleared", 1'b0, irq)
      auto_ack <= 1'b1;
      gen <= 1'b1;
      w_low <= 1'b1;
      wait_edges(3);
      w_low <= 1'b0;
      wait_edges(10);
      rd(4'h0);
      `CHK("vector clear", 8'h11, rdata_o)
      wr(4'h0, 8'h01);
      w_low <= 1'b1;
      wait_edges(6);
      w_low <= 1'b0;
      `CHK("masked", 1'b0, sl_irq)
      rd(4'h0);
      `CHK("masked flag", 8'h21, rdata_o)
      @(posedge mclk_i);
      pd <= 1'b1;
      wait_edges(2);
      `CHK("detector stopped", 1'b0, bo_on)
      wr(4'h0, 8'h40);
      `CHK("detector running", 1'b1, bo_on)
      wr(4'h1, 8'h01);
      w_brown <= 1'b1;
      wait_edges(6);
      `CHK("brownout reset", 1'b1, int_rst)
      `CHK("sensor back on", 1'b1, ts_on)
      rd(4'h4);
      `CHK("cause brownout", 8'h02, rdata_o)
      rd(4'h1);
      `CHK("disable cleared", 8'h00, rdata_o)
      w_brown <= 1'b0;
      pd <= 1'b0;
      wait_edges(6);
      wr(4'h4, 8'h02);
      `CHK("brownout released", 1'b0, int_rst)
      complete_run();
   end
endmodule
`default_nettype wire

// >>> design/sts_map.svh
/*
 * register offsets, field positions and reset values of the supply and
 * temperature supervisor.
 * assumes: included by the design file only, by bare name.
 */
`ifndef STS_MAP_SVH
`define STS_MAP_SVH

`define STS_ADDR_W          4
`define STS_OFF_MON         4'h0
`define STS_OFF_TEMP        4'h1
`define STS_OFF_IRQ_STAT    4'h2
`define STS_OFF_IRQ_MASK    4'h3
`define STS_OFF_RST_CAUSE   4'h4

`define STS_MON_ON_BIT      0
`define STS_MON_LVL_LO      1
`define STS_MON_LVL_HI      3
`define STS_MON_IMASK_BIT   4
`define STS_MON_FLAG_BIT    5
`define STS_MON_BOPD_BIT    6
`define STS_MON_BOLS_BIT    7
`define STS_TEMP_DIS_BIT    0

`define STS_RC_OT_BIT       0
`define STS_RC_BO_BIT       1

`define STS_IRQ_SUPPLY_BIT  0
`define STS_IRQ_BROWN_BIT   1
`define STS_IRQ_OT_BIT      2
`define STS_IRQ_MSB         2

`define STS_RESET_BYTE      8'h00
`define STS_LVL_RESERVED_LO 3'h6

`endif

// >>> design/sts_pkg.sv
/*
 * types of the supply and temperature supervisor.
 * assumes: compiled before the design file.
 */
package sts_pkg;
   typedef logic [7:0] sts_byte_t;
   typedef logic [2:0] sts_level_t;
endpackage

// >>> design/sts_supervisor.sv
/*
 * supply voltage monitor, brown-out detector and over-temperature shutdown
 * control and status, with a plain register port and two level interrupts.
 * assumes: comparator inputs are asynchronous; the cpu pulses the vector
 * acknowledge when it runs the supply-low vector; reset handling outside.
 */
// Summary of operation
// R1: bit 0 of the temperature control register disables overtemp shutdown when one.
// R2: every reset returns the overtemp disable bit to zero, enabling shutdown.
// R3: the overtemp flag is set from the comparator only while the disable bit is zero.
// R4: a set overtemp flag forces reset at once, holding ports and interval timer off.
// R5: bits 7..1 of the temperature control register are read-only and read zero.
// R6: bit 0 of the monitor register enables the voltage monitor.
// R7: bits 3..1 choose one of six monitor thresholds, codes 6 and 7 reserved.
// R8: bit 5 flag sets while the enabled monitor sees supply below threshold.
// R9: the supply-low flag clears when the cpu runs its interrupt vector.
// R10: writing one to bit 5 clears the flag, writing zero keeps it.
// R11: bit 4 mask with flag and global enable raises the supply-low request.
// R12: bit 7 picks the brown-out level, zero 1.8 V and one 2.0 V.
// R13: bit 6 keeps brown-out detection running in power-down when one.
// R14: the brown-out flag sets on low supply and holds internal reset while set.
// R15: comparator and sensor inputs pass two flip-flops before use.
`timescale 1ns/1ps
`default_nettype none
`include "sts_map.svh"

module sts_supervisor (
   // clock and reset
   input  wire logic                   mclk_i,
   input  wire logic                   rst_i,
   // register port
   input  wire logic [`STS_ADDR_W-1:0] addr_i,
   input  wire logic [7:0]             wdata_i,
   input  wire logic                   wr_i,
   input  wire logic                   rd_i,
   output logic      [7:0]             rdata_o,
   // cpu side
   input  wire logic                   global_irq_en_i,
   input  wire logic                   supply_vec_ack_i,
   input  wire logic                   powerdown_i,
   output logic                        supply_low_irq_o,
   output logic                        irq_o,
   // analog side
   input  wire logic                   supply_low_cmp_i,
   input  wire logic                   brownout_cmp_i,
   input  wire logic                   overtemp_cmp_i,
   output logic      [2:0]             supply_monitor_level_o,
   output logic                        supply_monitor_on_o,
   output logic                        brownout_level_sel_o,
   output logic                        brownout_det_on_o,
   output logic                        temp_sensor_on_o,
   // reset request and hold-off
   output logic                        internal_reset_o,
   output logic                        periph_hold_o
);

   ////////////////////////////////////////////////////////////////////////
   // synchronisers

   logic supply_low_s;
   logic brownout_s;
   logic overtemp_s;

   // each comparator level passes its own two-stage synchroniser
   sts_sync2 #(
      .RESET_LEVEL (1'b0)
   ) u_sync_low (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .d_i         (supply_low_cmp_i),                                      // [R15]
      .q_o         (supply_low_s)
   );

   sts_sync2 #(
      .RESET_LEVEL (1'b0)
   ) u_sync_brown (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .d_i         (brownout_cmp_i),                                        // [R15]
      .q_o         (brownout_s)
   );

   sts_sync2 #(
      .RESET_LEVEL (1'b0)
   ) u_sync_hot (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .d_i         (overtemp_cmp_i),                                        // [R15]
      .q_o         (overtemp_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // control bits

   logic                 supply_monitor_on;
   sts_pkg::sts_level_t  supply_monitor_level;
   logic                 supply_low_irq_mask;
   logic                 brownout_in_powerdown;
   logic                 brownout_level_sel;
   logic                 overtemp_disable;
   logic                 supply_low_flag;
   logic                 overtemp_reset_flag;
   logic                 brownout_reset_flag;
   logic [2:0]           irq_stat;
   logic [2:0]           irq_mask;

   wire logic wr_mon  = wr_i && (addr_i == `STS_OFF_MON);
   wire logic wr_temp = wr_i && (addr_i == `STS_OFF_TEMP);
   wire logic wr_stat = wr_i && (addr_i == `STS_OFF_IRQ_STAT);
   wire logic wr_mask = wr_i && (addr_i == `STS_OFF_IRQ_MASK);
   wire logic wr_rc   = wr_i && (addr_i == `STS_OFF_RST_CAUSE);

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         supply_monitor_on <= 1'b0;
      end else if (wr_mon) begin
         supply_monitor_on <= wdata_i[`STS_MON_ON_BIT];                        // [R6]
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         supply_monitor_level <= 3'h0;
      end else if (wr_mon) begin
         supply_monitor_level <= wdata_i[`STS_MON_LVL_HI:`STS_MON_LVL_LO];     // [R7]
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         supply_low_irq_mask <= 1'b0;
      end else if (wr_mon) begin
         supply_low_irq_mask <= wdata_i[`STS_MON_IMASK_BIT];                   // [R11]
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         brownout_in_powerdown <= 1'b0;
      end else if (wr_mon) begin
         brownout_in_powerdown <= wdata_i[`STS_MON_BOPD_BIT];                  // [R13]
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         brownout_level_sel <= 1'b0;
      end else if (wr_mon) begin
         brownout_level_sel <= wdata_i[`STS_MON_BOLS_BIT];                     // [R12]
      end
   end

   // overtemp reset clears the disable bit too, since it is an internal reset
   always_ff @(posedge mclk_i) begin
      if (rst_i || overtemp_reset_flag || brownout_reset_flag) begin
         overtemp_disable <= 1'b0;                                 // [R2]
      end else if (wr_temp) begin
         overtemp_disable <= wdata_i[`STS_TEMP_DIS_BIT];           // [R1]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flags

   wire logic supply_low_set = supply_monitor_on && supply_low_s;            // [R8]
   wire logic bo_active      = !powerdown_i || brownout_in_powerdown;        // [R13]
   wire logic brownout_set   = bo_active && brownout_s;                       // [R14]
   wire logic overtemp_set   = !overtemp_disable && overtemp_s;               // [R3]

   // set wins over vector acknowledge and over write-one-to-clear
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         supply_low_flag <= 1'b0;
      end else if (supply_low_set) begin
         supply_low_flag <= 1'b1;                                             // [R8]
      end else if (supply_vec_ack_i) begin
         supply_low_flag <= 1'b0;                                             // [R9]
      end else if (wr_mon && wdata_i[`STS_MON_FLAG_BIT]) begin
         supply_low_flag <= 1'b0;                                             // [R10]
      end
   end

   // reset cause flags survive the internal reset they cause
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         overtemp_reset_flag <= 1'b0;
      end else if (overtemp_set) begin
         overtemp_reset_flag <= 1'b1;                                         // [R3]
      end else if (wr_rc && wdata_i[`STS_RC_OT_BIT]) begin
         overtemp_reset_flag <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         brownout_reset_flag <= 1'b0;
      end else if (brownout_set) begin
         brownout_reset_flag <= 1'b1;                                         // [R14]
      end else if (wr_rc && wdata_i[`STS_RC_BO_BIT]) begin
         brownout_reset_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt status and mask

   logic [2:0] irq_events;
   always_comb begin
      irq_events = 3'h0;
      irq_events[`STS_IRQ_SUPPLY_BIT] = supply_low_set;
      irq_events[`STS_IRQ_BROWN_BIT]  = brownout_set;
      irq_events[`STS_IRQ_OT_BIT]     = overtemp_set;
   end

   // a status bit whose event lands with its clear stays set
   logic [`STS_IRQ_MSB:0] next_irq_stat;
   always_comb begin
      next_irq_stat = irq_stat;
      if (wr_stat) begin
         next_irq_stat = irq_stat & ~wdata_i[`STS_IRQ_MSB:0];
      end
      next_irq_stat = next_irq_stat | irq_events;
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         irq_stat <= 3'h0;
      end else begin
         irq_stat <= next_irq_stat;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         irq_mask <= 3'h0;
      end else if (wr_mask) begin
         irq_mask <= wdata_i[`STS_IRQ_MSB:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   logic next_supply_irq;
   logic next_irq;
   logic next_reset;
   always_comb begin
      next_supply_irq = supply_low_irq_mask && supply_low_flag && global_irq_en_i; // [R11]
      next_irq        = |(irq_stat & irq_mask);
      next_reset      = overtemp_reset_flag || brownout_reset_flag;                // [R4] [R14]
   end

   // interrupt requests
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         supply_low_irq_o <= 1'b0;
         irq_o            <= 1'b0;
      end else begin
         supply_low_irq_o <= next_supply_irq;                                  // [R11]
         irq_o            <= next_irq;
      end
   end

   // reset request and hold-off of ports and interval timer
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         internal_reset_o <= 1'b0;
         periph_hold_o    <= 1'b0;
      end else begin
         internal_reset_o <= next_reset;                                       // [R14]
         periph_hold_o    <= overtemp_reset_flag;                              // [R4]
      end
   end

   // controls of the monitor and brown-out comparators
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         supply_monitor_level_o <= 3'h0;
         supply_monitor_on_o    <= 1'b0;
         brownout_level_sel_o   <= 1'b0;
      end else begin
         supply_monitor_level_o <= supply_monitor_level;                       // [R7]
         supply_monitor_on_o    <= supply_monitor_on && !overtemp_reset_flag;  // [R4] [R6]
         brownout_level_sel_o   <= brownout_level_sel;                         // [R12]
      end
   end

   // power of the brown-out detector and the temperature sensor
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         brownout_det_on_o <= 1'b0;
         temp_sensor_on_o  <= 1'b0;
      end else begin
         brownout_det_on_o <= bo_active;                                       // [R13]
         temp_sensor_on_o  <= !overtemp_disable;                               // [R1] [R4]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port

   sts_pkg::sts_byte_t next_rdata;
   always_comb begin
      next_rdata = `STS_RESET_BYTE;
      unique case (addr_i)
         `STS_OFF_MON: begin
            next_rdata[`STS_MON_ON_BIT]                 = supply_monitor_on;
            next_rdata[`STS_MON_LVL_HI:`STS_MON_LVL_LO] = supply_monitor_level;
            next_rdata[`STS_MON_IMASK_BIT]              = supply_low_irq_mask;
            next_rdata[`STS_MON_FLAG_BIT]               = supply_low_flag;
            next_rdata[`STS_MON_BOPD_BIT]               = brownout_in_powerdown;
            next_rdata[`STS_MON_BOLS_BIT]               = brownout_level_sel;
         end
         `STS_OFF_TEMP: begin
            next_rdata[`STS_TEMP_DIS_BIT] = overtemp_disable;                // [R5]
         end
         `STS_OFF_IRQ_STAT: begin
            next_rdata[`STS_IRQ_MSB:0] = irq_stat;
         end
         `STS_OFF_IRQ_MASK: begin
            next_rdata[`STS_IRQ_MSB:0] = irq_mask;
         end
         `STS_OFF_RST_CAUSE: begin
            next_rdata[`STS_RC_OT_BIT] = overtemp_reset_flag;
            next_rdata[`STS_RC_BO_BIT] = brownout_reset_flag;
         end
         default: begin
            next_rdata = `STS_RESET_BYTE;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_o <= `STS_RESET_BYTE;
      end else if (rd_i) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= `STS_RESET_BYTE;
      end
   end

endmodule

////////////////////////////////////////////////////////////////////////////
// two flip-flop synchroniser for one asynchronous level

module sts_sync2 #(
   parameter logic RESET_LEVEL = 1'b0
) (
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_i,
   // asynchronous level in, clock-domain level out
   input  wire logic d_i,
   output logic      q_o
);

   logic meta;

   // nothing but the second stage may read the first
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         meta <= RESET_LEVEL;
         q_o  <= RESET_LEVEL;
      end else begin
         meta <= d_i;                                                          // [R15]
         q_o  <= meta;                                                         // [R15]
      end
   end

endmodule

`default_nettype wire
